/* File: rtl/irq_sched_pkg.sv */
// Constants shared by the interrupt scheduler files
package irq_sched_pkg;
    localparam int unsigned NUM_SRC = 128;
    localparam int unsigned NUM_SW = 8;
    localparam int unsigned NUM_HW = NUM_SRC - NUM_SW;
    localparam int unsigned SRC_W = 7;
    localparam int unsigned VEC_W = 9;
    localparam int unsigned PRIO_W = 4;
    localparam int unsigned NUM_LEVELS = 16;
    localparam int unsigned SP_W = 5;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 4'h0;
    localparam logic [PRIO_W-1:0] MASK_RESET = 4'h0;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [SP_W-1:0] SP_FULL = 5'h10;
    // Vector is the source number zero-extended; bits above it are this base
    localparam logic [VEC_W-SRC_W-1:0] VEC_BASE = 2'h0;
endpackage : irq_sched_pkg

/* File: rtl/sw_irq_flag.sv */
// Sticky software interrupt flag, set wins over clear
`timescale 1ns/1ns
module sw_irq_flag (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Set and clear strobes
    input wire logic set,
    input wire logic clr,
    // Flag
    output logic flag
);
    logic flag_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end

    assign flag = flag_q;
endmodule : sw_irq_flag

/* File: rtl/interrupt_scheduler.sv */
// Priority preemptive interrupt scheduler with vectored and critical outputs
// Notes on behaviour
// - Up to 128 request sources, each with its own priority level.
// - Winning source is presented as a unique 9-bit vector.
// - Software assigns each source one of 16 levels, used in arbitration.
// - Equal levels resolve by fixed order, lowest source number wins.
// - Only requests above current priority reach the core; lower never delay.
// - Writable current priority mask blocks requests at or below it.
// - Eight software-set sources arbitrate like hardware sources.
// - Non-maskable input drives critical output, bypassing arbitration and mask.
`timescale 1ns/1ns
module interrupt_scheduler #(
    parameter int unsigned NUM_SRC = irq_sched_pkg::NUM_SRC,
    parameter int unsigned NUM_SW = irq_sched_pkg::NUM_SW
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Hardware request levels
    input wire logic [NUM_SRC-NUM_SW-1:0] IRQ_REQ,
    // Software sources
    input wire logic [NUM_SW-1:0] SW_SET,
    input wire logic [NUM_SW-1:0] SW_CLR,
    // Priority table write
    input wire logic PRIO_WR,
    input wire logic [irq_sched_pkg::SRC_W-1:0] PRIO_SEL,
    input wire logic [irq_sched_pkg::PRIO_W-1:0] PRIO_VAL,
    // Current priority mask write
    input wire logic MASK_WR,
    input wire logic [irq_sched_pkg::PRIO_W-1:0] MASK_VAL,
    // Core handshake
    input wire logic ACK,
    input wire logic EOI,
    // Non-maskable request
    input wire logic NMI_IN,
    // Outputs to the core
    output logic INT_REQ,
    output logic [irq_sched_pkg::VEC_W-1:0] INT_VEC,
    output logic [irq_sched_pkg::PRIO_W-1:0] INT_PRIO,
    output logic [irq_sched_pkg::PRIO_W-1:0] CUR_PRIO,
    output logic [NUM_SW-1:0] SW_PEND,
    output logic CRIT_INT
);
    localparam int unsigned NUM_HW = NUM_SRC - NUM_SW;

    logic [NUM_SRC-1:0] pend;
    logic [NUM_SW-1:0] sw_flag;
    logic [irq_sched_pkg::PRIO_W-1:0] prio_tab_q [NUM_SRC];
    logic [irq_sched_pkg::PRIO_W-1:0] stack_q [irq_sched_pkg::NUM_LEVELS];
    logic [irq_sched_pkg::SP_W-1:0] sp_q;
    logic [irq_sched_pkg::PRIO_W-1:0] cur_q;
    logic win_valid;
    logic [irq_sched_pkg::SRC_W-1:0] win_src;
    logic [irq_sched_pkg::PRIO_W-1:0] win_prio;
    logic req_q;
    logic [irq_sched_pkg::VEC_W-1:0] vec_q;
    logic [irq_sched_pkg::PRIO_W-1:0] int_prio_q;
    logic crit_q;
    logic take;

    genvar g;
    generate
        for (g = 0; g < NUM_SW; g++) begin : g_sw
            sw_irq_flag u_flag (
                .clk(SYS_CLK),
                .rst(RST),
                .set(SW_SET[g]),
                .clr(SW_CLR[g]),
                .flag(sw_flag[g])
            );
        end
    endgenerate

    assign pend = {IRQ_REQ[NUM_HW-1:0], sw_flag};

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_tab_q[i] <= irq_sched_pkg::PRIO_RESET;
            end
        end else if (PRIO_WR) begin
            prio_tab_q[PRIO_SEL] <= PRIO_VAL;
        end
    end

    always_comb begin
        win_valid = 1'b0;
        win_src = '0;
        win_prio = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (pend[i] && prio_tab_q[i] > win_prio) begin
                win_valid = 1'b1;
                win_src = irq_sched_pkg::SRC_W'(i);
                win_prio = prio_tab_q[i];
            end
        end
    end

    // Nesting stack and next-state signals
    logic push;
    logic pop;
    logic stack_full;
    logic stack_empty;
    logic [irq_sched_pkg::SP_W-2:0] top_idx;
    logic [irq_sched_pkg::SP_W-1:0] sp_d;
    logic [irq_sched_pkg::PRIO_W-1:0] cur_d;
    logic above;
    logic req_d;
    logic [irq_sched_pkg::VEC_W-1:0] vec_d;
    logic [irq_sched_pkg::PRIO_W-1:0] int_prio_d;

    assign stack_full = (sp_q == irq_sched_pkg::SP_FULL);
    assign stack_empty = (sp_q == irq_sched_pkg::SP_RESET);
    assign top_idx = sp_q[irq_sched_pkg::SP_W-2:0] - 1'b1;

    // accept only a presented request with stack room
    assign take = ACK && req_q && !stack_full;
    assign push = take;
    assign pop = EOI && !stack_empty && !take;

    // next current priority and stack pointer
    always_comb begin
        sp_d = sp_q;
        cur_d = cur_q;
        if (push) begin
            sp_d = sp_q + 1'b1;
            cur_d = int_prio_q;
        end else if (pop) begin
            sp_d = sp_q - 1'b1;
            cur_d = stack_q[top_idx];
        end else if (MASK_WR) begin
            cur_d = MASK_VAL;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            for (int i = 0; i < irq_sched_pkg::NUM_LEVELS; i++) begin
                stack_q[i] <= irq_sched_pkg::MASK_RESET;
            end
        end else if (push) begin
            stack_q[sp_q[irq_sched_pkg::SP_W-2:0]] <= cur_q;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sp_q <= irq_sched_pkg::SP_RESET;
        end else begin
            sp_q <= sp_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cur_q <= irq_sched_pkg::MASK_RESET;
        end else begin
            cur_q <= cur_d;
        end
    end

    assign above = win_valid && (win_prio > cur_q);

    always_comb begin
        req_d = above && !take;
        vec_d = vec_q;
        int_prio_d = int_prio_q;
        if (above) begin
            vec_d = {irq_sched_pkg::VEC_BASE, win_src};
            int_prio_d = win_prio;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            req_q <= 1'b0;
        end else begin
            req_q <= req_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            vec_q <= '0;
        end else begin
            vec_q <= vec_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            int_prio_q <= '0;
        end else begin
            int_prio_q <= int_prio_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            crit_q <= 1'b0;
        end else begin
            crit_q <= NMI_IN;
        end
    end

    assign INT_REQ = req_q;
    assign INT_VEC = vec_q;
    assign INT_PRIO = int_prio_q;
    assign CUR_PRIO = cur_q;
    assign SW_PEND = sw_flag;
    assign CRIT_INT = crit_q;
endmodule : interrupt_scheduler

/* File: dv/irq_sched_sva.sv */
// Port assertions for the interrupt scheduler
`timescale 1ns/1ns
module irq_sched_sva #(
    parameter int unsigned NUM_SW = 8
) (
    // Watched ports
    input wire logic SYS_CLK, RST, NMI_IN, CRIT_INT, INT_REQ, ACK, EOI, MASK_WR,
    input wire logic [8:0] INT_VEC,
    input wire logic [3:0] INT_PRIO, CUR_PRIO, MASK_VAL,
    input wire logic [NUM_SW-1:0] SW_SET, SW_PEND
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_nmi_pass: assert property (NMI_IN |=> CRIT_INT)
        else $error("critical missed");
    a_nmi_drop: assert property (!NMI_IN |=> !CRIT_INT)
        else $error("critical stuck");
    a_req_above: assert property (INT_REQ && $stable(CUR_PRIO) |-> INT_PRIO > CUR_PRIO)
        else $error("request not above current");
    a_req_level: assert property (INT_REQ |-> INT_PRIO != 4'h0)
        else $error("level zero requested");
    a_vec_top: assert property (INT_REQ |-> INT_VEC[8:7] == 2'h0)
        else $error("vector upper bits");
    a_ack_load: assert property (ACK && INT_REQ |=> CUR_PRIO == $past(INT_PRIO))
        else $error("ack level not loaded");
    a_mask_load: assert property (MASK_WR && !ACK && !EOI |=> CUR_PRIO == $past(MASK_VAL))
        else $error("mask not loaded");
    a_sw_set: assert property (|SW_SET |=> (SW_PEND & $past(SW_SET)) == $past(SW_SET))
        else $error("soft flag not set");
endmodule : irq_sched_sva
bind interrupt_scheduler irq_sched_sva #(.NUM_SW(NUM_SW)) i_irq_sched_sva (.SYS_CLK(SYS_CLK),
    .RST(RST), .NMI_IN(NMI_IN), .CRIT_INT(CRIT_INT), .INT_REQ(INT_REQ), .ACK(ACK), .EOI(EOI),
    .MASK_WR(MASK_WR), .INT_VEC(INT_VEC), .INT_PRIO(INT_PRIO), .CUR_PRIO(CUR_PRIO),
    .MASK_VAL(MASK_VAL), .SW_SET(SW_SET), .SW_PEND(SW_PEND));

/* File: dv/core_model.sv */
// Core model: accepts a request, then ends service
`timescale 1ns/1ns
module core_model #(
    parameter int SVC = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic req,
    output logic ack,
    output logic eoi
);
    int n = 0;
    always @(negedge clk) begin
        ack <= 1'b0;
        eoi <= 1'b0;
        if (rst) begin
            n <= 0;
        end else if (n > 1) begin
            n <= n - 1;
        end else if (n == 1) begin
            eoi <= 1'b1;
            n <= 0;
        end else if (req && en) begin
            ack <= 1'b1;
            n <= SVC;
        end
    end
endmodule : core_model

/* File: dv/interrupt_scheduler_test.sv */
// Testbench for the interrupt scheduler
`timescale 1ns/1ns
module interrupt_scheduler_test;
    logic SYS_CLK = 0, RST = 1, PRIO_WR = 0, MASK_WR = 0, NMI_IN = 0, en = 0;
    logic ACK, EOI, INT_REQ, CRIT_INT;
    logic [119:0] IRQ_REQ = 120'h0;
    logic [7:0] SW_SET = 8'h00, SW_CLR = 8'h00, SW_PEND;
    logic [6:0] PRIO_SEL = 7'h00;
    logic [3:0] PRIO_VAL = 4'h0, MASK_VAL = 4'h0, INT_PRIO, CUR_PRIO;
    logic [8:0] INT_VEC;
    int mismatches = 0, num_checks = 0, cyc = 0;
    interrupt_scheduler i_interrupt_scheduler (.SYS_CLK, .RST, .IRQ_REQ, .SW_SET, .SW_CLR,
        .PRIO_WR, .PRIO_SEL, .PRIO_VAL, .MASK_WR, .MASK_VAL, .ACK, .EOI, .NMI_IN, .INT_REQ,
        .INT_VEC, .INT_PRIO, .CUR_PRIO, .SW_PEND, .CRIT_INT);
    core_model i_core_model (.clk(SYS_CLK), .rst(RST), .en(en), .req(INT_REQ), .ack(ACK),
        .eoi(EOI));
    always #5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    task tick(input int n); repeat (n) @(negedge SYS_CLK); endtask : tick
    task chk(input string nm, input logic [8:0] e, input logic [8:0] s);
        num_checks++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask : chk
    task wp(input logic [6:0] s, input logic [3:0] v);
        tick(1); PRIO_WR = 1; PRIO_SEL = s; PRIO_VAL = v;
        tick(1); PRIO_WR = 0;
    endtask : wp
    task wm(input logic [3:0] v);
        tick(1); MASK_WR = 1; MASK_VAL = v;
        tick(1); MASK_WR = 0; tick(1);
    endtask : wm
    task t_arb;
        wp(7'h7f, 4'h9); wp(7'h14, 4'h9); wp(7'h08, 4'h3);
        IRQ_REQ[119] = 1; IRQ_REQ[12] = 1; IRQ_REQ[0] = 1; tick(2);
        chk("vec", 9'h014, INT_VEC);
        wp(7'h7f, 4'hf); tick(1);
        chk("vec", 9'h07f, INT_VEC);
        chk("prio", 9'h00f, {5'h00, INT_PRIO});
        wm(4'hf); chk("req", 9'h000, {8'h00, INT_REQ});
        wm(4'he); chk("req", 9'h001, {8'h00, INT_REQ});
        NMI_IN = 1; tick(2); chk("crit", 9'h001, {8'h00, CRIT_INT});
        NMI_IN = 0; wm(4'h0); IRQ_REQ = 120'h0;
        $display("t_arb done");
    endtask : t_arb
    task t_soft;
        wp(7'h03, 4'h2); tick(1); SW_SET = 8'h08; tick(1); SW_SET = 8'h00; tick(2);
        chk("vec", 9'h003, INT_VEC);
        en <= 1'b1; tick(2); en <= 1'b0;
        chk("cur", 9'h002, {5'h00, CUR_PRIO});
        tick(6); chk("cur", 9'h000, {5'h00, CUR_PRIO});
        $display("t_soft done");
    endtask : t_soft
    task t_clr;
        SW_CLR = 8'h08; tick(1); SW_CLR = 8'h00;
        chk("pend", 9'h000, {1'b0, SW_PEND});
        tick(1); chk("req", 9'h000, {8'h00, INT_REQ});
        SW_SET = 8'h01; SW_CLR = 8'h01; tick(1); SW_SET = 8'h00; SW_CLR = 8'h00;
        chk("pend", 9'h001, {1'b0, SW_PEND});
        SW_CLR = 8'h01; tick(1); SW_CLR = 8'h00;
        chk("pend", 9'h000, {1'b0, SW_PEND});
        $display("t_clr done");
    endtask : t_clr
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    initial begin
        tick(3); RST = 0;
        t_arb(); t_soft(); t_clr();
        stop_test();
    end
endmodule : interrupt_scheduler_test
